/* hdl/lic_pkg.sv */
// package: register map, field positions and timing for the line control block
//
// Operation
// - cmi coder emits two half-bit symbols per data bit when cmi is on
// - a one bit is a single level held for the whole bit period
// - a zero bit is low in the first half, high in the second
// - bit 7 of control register four enables transmit and receive cmi together
// - positive transmit output carries cmi data at normal levels when enabled
// - hdb3 or b8zs substituted data may still feed the cmi coder
// - positive receive input is decoded as cmi with a free-running bit strobe; the decoder times its halves from when cmi comes on
// - power-down bit zero powers transmitter down and floats both outputs
// - transmit on only if power-down bit one and pin control allows it
// - jitter attenuator disable bit one removes the attenuator from the path
// - buffer depth bit zero selects 128 bits, one selects 32 bits
// - placement bit zero puts attenuator in receive path, one in transmit
// - gain limit bit picks sensitivity, meaning differs between t1 and e1
// - build-out codes 100 and 101 are accepted and passed through
// - auto gain disable zero uses agc, one uses the six-bit manual gain
package lic_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] LIC_OFS_CTRL_ONE = 8'h78;
  localparam logic [7:0] LIC_OFS_CTRL_TWO = 8'h79;
  localparam logic [7:0] LIC_OFS_CTRL_FOUR = 8'h7b;
  localparam logic [7:0] LIC_OFS_GAIN = 8'h7d;
  localparam logic [7:0] LIC_OFS_STATUS = 8'h7e;
  localparam logic [7:0] LIC_RST_VAL = 8'h00;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int LIC_B_TX_PD = 0;
  localparam int LIC_B_JA_DIS = 1;
  localparam int LIC_B_JA_DEPTH = 2;
  localparam int LIC_B_JA_SIDE = 3;
  localparam int LIC_B_EGL = 4;
  localparam int LIC_B_BO_LO = 5;
  localparam int LIC_B_ETS = 7;
  localparam int LIC_B_CMI_EN = 7;
  localparam int LIC_B_TT0 = 0;
  localparam int LIC_B_TT1 = 1;
  localparam int LIC_B_AGC_DIS = 6;
  // ----------------------------------------------------------------
  // jitter buffer depths in bits
  // ----------------------------------------------------------------
  localparam logic [7:0] LIC_JA_DEEP = 8'd128;
  localparam logic [7:0] LIC_JA_SHALLOW = 8'd32;
  // ----------------------------------------------------------------
  // receive sensitivity codes, magnitude of limit in db
  // ----------------------------------------------------------------
  localparam logic [5:0] LIC_EGL_T1_FULL = 6'd36;
  localparam logic [5:0] LIC_EGL_T1_LIM = 6'd15;
  localparam logic [5:0] LIC_EGL_E1_SHORT = 6'd12;
  localparam logic [5:0] LIC_EGL_E1_LONG = 6'd43;
  // ----------------------------------------------------------------
  // coder timing: half bit length in clk cycles
  // ----------------------------------------------------------------
  localparam int LIC_HALF_BIT = 2;
  // coder states
  typedef enum logic [2:0] {
    LIC_ST_IDLE = 3'b001,
    LIC_ST_FIRST = 3'b010,
    LIC_ST_SECOND = 3'b100
  } lic_state_type;
endpackage : lic_pkg

/* hdl/lic_buf.sv */
// two-entry valid/ready buffer for the transmit data path
`timescale 1ns/1ps
module lic_buf #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [WIDTH-1:0] mem_r [2];
  logic [WIDTH-1:0] mem_nxt [2];
  logic wp_r, wp_nxt, rp_r, rp_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic push, pop;
  logic rdy_r, rdy_nxt;

  // ready registered from the next count, so source stalls when full
  assign in_ready = rdy_r;
  assign out_valid = (cnt_r != 2'd0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // next pointers and count
  always_comb begin
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wp_r] = in_data;
      wp_nxt = ~wp_r;
    end
    if (pop) begin
      rp_nxt = ~rp_r;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 2'd1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 2'd1;
    end
    rdy_nxt = (cnt_nxt != 2'd2);
  end

  // register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'd0;
      rdy_r <= 1'b1;
    end else begin
      mem_r <= mem_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
    end
  end
endmodule : lic_buf

/* hdl/lic_top.sv */
// line interface control: registers, power-down decision, cmi coder/decoder
`timescale 1ns/1ps
module lic_top
  import lic_pkg::*;
#(
  parameter int HALF_BIT = LIC_HALF_BIT
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // pins
  input wire logic tx_power_down_pin,
  input wire logic pin_control_select,
  // transmit data, already zero-substituted upstream when wanted
  input wire logic tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // transmit line
  output logic tx_line_pos,
  output logic tx_line_pos_oe_n,
  output logic tx_line_neg,
  output logic tx_line_neg_oe_n,
  // receive line
  input wire logic rx_line_pos,
  output logic rx_data,
  output logic rx_clk_en,
  // analog controls
  output logic tx_enable,
  output logic ja_enable,
  output logic ja_on_tx_side,
  output logic [7:0] ja_depth,
  output logic [5:0] eq_limit_db,
  output logic [2:0] buildout_sel,
  output logic [5:0] tx_gain
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] line_ctrl_one_r, line_ctrl_one_nxt;
  logic [7:0] line_ctrl_two_r, line_ctrl_two_nxt;
  logic [7:0] line_ctrl_four_r, line_ctrl_four_nxt;
  logic [7:0] gain_ctrl_r, gain_ctrl_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic tx_on;
  logic cmi_on;

  // decode writes, build read answer
  always_comb begin
    line_ctrl_one_nxt = line_ctrl_one_r;
    line_ctrl_two_nxt = line_ctrl_two_r;
    line_ctrl_four_nxt = line_ctrl_four_r;
    gain_ctrl_nxt = gain_ctrl_r;
    rdata_nxt = 8'h00;
    if (wr) begin
      case (addr)
        // all eight build-out codes stored as written
        LIC_OFS_CTRL_ONE: line_ctrl_one_nxt = wdata;
        LIC_OFS_CTRL_TWO: line_ctrl_two_nxt = wdata;
        LIC_OFS_CTRL_FOUR: line_ctrl_four_nxt = wdata;
        LIC_OFS_GAIN: gain_ctrl_nxt = {1'b0, wdata[6:0]};
        default: ;
      endcase
    end
    if (rd) begin
      case (addr)
        LIC_OFS_CTRL_ONE: rdata_nxt = line_ctrl_one_r;
        LIC_OFS_CTRL_TWO: rdata_nxt = line_ctrl_two_r;
        LIC_OFS_CTRL_FOUR: rdata_nxt = line_ctrl_four_r;
        LIC_OFS_GAIN: rdata_nxt = gain_ctrl_r;
        LIC_OFS_STATUS: rdata_nxt = {6'h00, cmi_on, tx_on};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // register store; all zero leaves transmitter down
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_ctrl_one_r <= LIC_RST_VAL;
      line_ctrl_two_r <= LIC_RST_VAL;
      line_ctrl_four_r <= LIC_RST_VAL;
      gain_ctrl_r <= LIC_RST_VAL;
      rdata_r <= 8'h00;
    end else begin
      line_ctrl_one_r <= line_ctrl_one_nxt;
      line_ctrl_two_r <= line_ctrl_two_nxt;
      line_ctrl_four_r <= line_ctrl_four_nxt;
      gain_ctrl_r <= gain_ctrl_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign rdata = rdata_r;

  // ----------------------------------------------------------------
  // power-down decision
  // ----------------------------------------------------------------
  // bit one and pin either ignored or low
  assign tx_on = line_ctrl_one_r[LIC_B_TX_PD]
    && (!pin_control_select || !tx_power_down_pin);
  // one control bit covers both directions
  assign cmi_on = line_ctrl_four_r[LIC_B_CMI_EN];

  // ----------------------------------------------------------------
  // static control outputs
  // ----------------------------------------------------------------
  logic ja_en_nxt, ja_side_nxt;
  logic [7:0] depth_nxt;
  logic [5:0] eq_nxt, gain_nxt;
  logic ja_en_r, ja_side_r, tx_en_r;
  logic [7:0] depth_r;
  logic [5:0] eq_r, gain_r;
  logic [2:0] bo_r;

  // decode control fields
  always_comb begin
    ja_en_nxt = !line_ctrl_one_r[LIC_B_JA_DIS];
    depth_nxt = line_ctrl_one_r[LIC_B_JA_DEPTH] ? LIC_JA_SHALLOW
      : LIC_JA_DEEP;
    ja_side_nxt = line_ctrl_one_r[LIC_B_JA_SIDE];
    if (line_ctrl_two_r[LIC_B_ETS]) begin
      eq_nxt = line_ctrl_one_r[LIC_B_EGL] ? LIC_EGL_E1_LONG
        : LIC_EGL_E1_SHORT;
    end else begin
      eq_nxt = line_ctrl_one_r[LIC_B_EGL] ? LIC_EGL_T1_LIM
        : LIC_EGL_T1_FULL;
    end
    // zero means agc runs, manual field ignored
    gain_nxt = gain_ctrl_r[LIC_B_AGC_DIS] ? gain_ctrl_r[5:0]
      : 6'h00;
  end

  // register control outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ja_en_r <= 1'b1;
      ja_side_r <= 1'b0;
      depth_r <= LIC_JA_DEEP;
      eq_r <= LIC_EGL_T1_FULL;
      gain_r <= 6'h00;
      bo_r <= 3'h0;
      tx_en_r <= 1'b0;
    end else begin
      ja_en_r <= ja_en_nxt;
      ja_side_r <= ja_side_nxt;
      depth_r <= depth_nxt;
      eq_r <= eq_nxt;
      gain_r <= gain_nxt;
      bo_r <= line_ctrl_one_r[LIC_B_BO_LO +: 3];
      tx_en_r <= tx_on;
    end
  end
  assign ja_enable = ja_en_r;
  assign ja_on_tx_side = ja_side_r;
  assign ja_depth = depth_r;
  assign eq_limit_db = eq_r;
  assign tx_gain = gain_r;
  assign buildout_sel = bo_r;
  assign tx_enable = tx_en_r;

  // ----------------------------------------------------------------
  // cmi coder
  // ----------------------------------------------------------------
  logic buf_data, buf_valid, buf_ready;

  // buffer absorbs a stall while coder is busy or off
  lic_buf #(.WIDTH(1)) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_data(tx_data),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(buf_ready)
  );

  lic_state_type st_r, st_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic bit_r, bit_nxt;
  logic mark_r, mark_nxt;
  logic line_r, line_nxt;
  logic oe_n_r, oe_n_nxt;

  // coder takes a bit only when cmi and transmitter are on
  assign buf_ready = cmi_on && tx_on
    && ((st_r == LIC_ST_IDLE)
    || (st_r == LIC_ST_SECOND && cnt_r == 8'(HALF_BIT - 1)));

  // next state of the coder
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    bit_nxt = bit_r;
    mark_nxt = mark_r;
    line_nxt = line_r;
    oe_n_nxt = !tx_on;
    case (st_r)
      LIC_ST_IDLE: begin
        line_nxt = 1'b0;
      end
      LIC_ST_FIRST: begin
        if (cnt_r == 8'(HALF_BIT - 1)) begin
          st_nxt = LIC_ST_SECOND;
          cnt_nxt = 8'h00;
          // zero rises at mid period, one holds
          line_nxt = bit_r ? mark_r : 1'b1;
        end else begin
          cnt_nxt = cnt_r + 8'h01;
        end
      end
      LIC_ST_SECOND: begin
        if (cnt_r == 8'(HALF_BIT - 1)) begin
          st_nxt = LIC_ST_IDLE;
          cnt_nxt = 8'h00;
          line_nxt = 1'b0;
        end else begin
          cnt_nxt = cnt_r + 8'h01;
        end
      end
      default: begin
        st_nxt = LIC_ST_IDLE;
        cnt_nxt = 8'h00;
      end
    endcase
    // each bit split into two half-period symbols
    if (buf_valid && buf_ready) begin
      st_nxt = LIC_ST_FIRST;
      cnt_nxt = 8'h00;
      bit_nxt = buf_data;
      if (buf_data) begin
        line_nxt = !mark_r;
        mark_nxt = !mark_r;
      end else begin
        line_nxt = 1'b0;
      end
    end
    if (!cmi_on || !tx_on) begin
      st_nxt = LIC_ST_IDLE;
      line_nxt = 1'b0;
    end
  end

  // coder registers; mark starts low so first one goes high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= LIC_ST_IDLE;
      cnt_r <= 8'h00;
      bit_r <= 1'b0;
      mark_r <= 1'b0;
      line_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      bit_r <= bit_nxt;
      mark_r <= mark_nxt;
      line_r <= line_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end
  // positive output carries the cmi stream; negative held low
  assign tx_line_pos = line_r;
  assign tx_line_pos_oe_n = oe_n_r;
  assign tx_line_neg = 1'b0;
  assign tx_line_neg_oe_n = oe_n_r;

  // ----------------------------------------------------------------
  // cmi decoder: samples each half period, second-half sample compared with the first
  // ----------------------------------------------------------------
  logic [7:0] rcnt_r, rcnt_nxt;
  logic half_r, half_nxt;
  logic first_r, first_nxt;
  logic rdat_r, rdat_nxt;
  logic rstb_r, rstb_nxt;

  // a half that differs from the other means a zero
  always_comb begin
    rcnt_nxt = rcnt_r;
    half_nxt = half_r;
    first_nxt = first_r;
    rdat_nxt = rdat_r;
    rstb_nxt = 1'b0;
    if (!cmi_on) begin
      rcnt_nxt = 8'h00;
      half_nxt = 1'b0;
    end else if (rcnt_r == 8'(HALF_BIT - 1)) begin
      rcnt_nxt = 8'h00;
      half_nxt = !half_r;
      if (!half_r) begin
        first_nxt = rx_line_pos;
      end else begin
        rdat_nxt = (first_r == rx_line_pos);
        rstb_nxt = 1'b1;
      end
    end else begin
      rcnt_nxt = rcnt_r + 8'h01;
    end
  end

  // decoder registers; strobe marks each bit, timed from when cmi comes on, not from the line
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rcnt_r <= 8'h00;
      half_r <= 1'b0;
      first_r <= 1'b0;
      rdat_r <= 1'b0;
      rstb_r <= 1'b0;
    end else begin
      rcnt_r <= rcnt_nxt;
      half_r <= half_nxt;
      first_r <= first_nxt;
      rdat_r <= rdat_nxt;
      rstb_r <= rstb_nxt;
    end
  end
  assign rx_data = rdat_r;
  assign rx_clk_en = rstb_r;
endmodule : lic_top

/* bench/lic_optic.sv */
// optical transport model: drives a cmi coded stream into the receive line
`timescale 1ns/1ps
module lic_optic (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // stream control
  input wire logic send,
  input wire logic [7:0] pattern,
  // line
  output logic rx_line_pos
);
  logic [4:0] ph_r; // bit index and quarter-bit phase
  logic lvl_r; // level of the last one sent

  // two cycles a half bit; idle line toggles so no stale level is seen
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_r <= 5'h00;
      lvl_r <= 1'b0;
      rx_line_pos <= 1'b0;
    end else if (!send) begin
      ph_r <= 5'h00;
      rx_line_pos <= ~rx_line_pos;
    end else begin
      ph_r <= ph_r + 5'h01;
      if (!pattern[ph_r[4:2]]) begin
        rx_line_pos <= ph_r[1]; // zero: low half, then high
      end else if (ph_r[1:0] == 2'h0) begin
        lvl_r <= ~lvl_r;
        rx_line_pos <= ~lvl_r; // one: whole period, alternating
      end
    end
  end
endmodule : lic_optic

/* bench/lic_top_asserts.sv */
// checker: timing relations on the line control block ports
`timescale 1ns/1ps
module lic_top_asserts
  import lic_pkg::*;
#(
  parameter int HALF_BIT = LIC_HALF_BIT
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // pins and line
  input wire logic tx_power_down_pin,
  input wire logic pin_control_select,
  input wire logic tx_line_pos_oe_n,
  input wire logic tx_line_neg_oe_n,
  input wire logic rx_clk_en,
  // decodes
  input wire logic tx_enable,
  input wire logic ja_enable,
  input wire logic ja_on_tx_side,
  input wire logic [7:0] ja_depth,
  input wire logic [2:0] buildout_sel
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // sequences and properties
  // ----------------------------------------
  sequence wr_one;
    wr && addr == LIC_OFS_CTRL_ONE;
  endsequence

  // decodes land two edges after the write is taken
  property ctrl_map_p;
    logic [7:0] d;
    (wr_one, d = wdata) |-> ##2 ja_enable == !d[1] &&
      ja_on_tx_side == d[3] && buildout_sel == d[7:5] &&
      ja_depth == (d[2] ? LIC_JA_SHALLOW : LIC_JA_DEEP);
  endproperty

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  oe_pair_a: assert property (
    tx_line_neg_oe_n == tx_line_pos_oe_n)
    else $error("line enables differ");
  pd_float_a: assert property (
    !tx_enable [*3] |-> tx_line_pos_oe_n)
    else $error("line driven while powered down");
  pin_block_a: assert property (
    (pin_control_select && tx_power_down_pin) [*2] |-> !tx_enable)
    else $error("pin did not power down");
  ctrl_map_a: assert property (ctrl_map_p)
    else $error("control decode wrong");
  rd_quiet_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  hole_read_a: assert property (rd && addr == 8'h00 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  status_zero_a: assert property (
    rd && addr == LIC_OFS_STATUS |=> rdata[7:2] == 6'h00)
    else $error("status upper bits set");
  gain_top_a: assert property (
    rd && addr == LIC_OFS_GAIN |=> !rdata[7])
    else $error("gain bit 7 reads one");
  rx_pace_a: assert property (
    rx_clk_en |=> !rx_clk_en [*3])
    else $error("receive bits too close");
endmodule : lic_top_asserts

bind lic_top lic_top_asserts #(.HALF_BIT(HALF_BIT)) u_chk (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .tx_power_down_pin(tx_power_down_pin),
  .pin_control_select(pin_control_select),
  .tx_line_pos_oe_n(tx_line_pos_oe_n),
  .tx_line_neg_oe_n(tx_line_neg_oe_n), .rx_clk_en(rx_clk_en),
  .tx_enable(tx_enable), .ja_enable(ja_enable),
  .ja_on_tx_side(ja_on_tx_side), .ja_depth(ja_depth),
  .buildout_sel(buildout_sel)
);

/* bench/test_line_interface_control_cmi.sv */
// self-checking bench for the line control block and its cmi coder
`timescale 1ns/1ps
module test_line_interface_control_cmi;
  import lic_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic pin = 1'b0;
  logic pcs = 1'b0;
  logic tx_data = 1'b0;
  logic tx_valid = 1'b0;
  logic send = 1'b0;
  logic [7:0] pattern = 8'h00;
  logic [7:0] rdata, ja_depth;
  logic tx_ready, tx_line_pos, pos_oe_n, tx_line_neg, neg_oe_n;
  logic rx_line_pos, rx_data, rx_clk_en, tx_enable, ja_enable, ja_tx;
  logic [5:0] eq_limit_db, tx_gain;
  logic [2:0] buildout_sel;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;

  always #50 clk = ~clk;

  lic_top #(.HALF_BIT(2)) uut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .tx_power_down_pin(pin),
    .pin_control_select(pcs), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_line_pos(tx_line_pos),
    .tx_line_pos_oe_n(pos_oe_n), .tx_line_neg(tx_line_neg),
    .tx_line_neg_oe_n(neg_oe_n), .rx_line_pos(rx_line_pos),
    .rx_data(rx_data), .rx_clk_en(rx_clk_en), .tx_enable(tx_enable),
    .ja_enable(ja_enable), .ja_on_tx_side(ja_tx), .ja_depth(ja_depth),
    .eq_limit_db(eq_limit_db), .buildout_sel(buildout_sel),
    .tx_gain(tx_gain)
  );

  lic_optic u_optic (
    .clk(clk), .rst_n(rst_n), .send(send), .pattern(pattern),
    .rx_line_pos(rx_line_pos)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(string what, logic [7:0] a, logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(what, exp, rdata);
  endtask : rd_chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd_chk("ctrl one", LIC_OFS_CTRL_ONE, LIC_RST_VAL);
    wr_reg(8'h00, 8'hff);
    rd_chk("hole", 8'h00, 8'h00);
    chk("oe_n", 8'h01, pos_oe_n);
    chk("ja on", 8'h01, ja_enable);
    chk("depth", LIC_JA_DEEP, ja_depth);
    $display("test reset done");
  endtask : t_reset

  // every field pattern, both modes, all build-out codes
  task automatic t_fields();
    logic [7:0] v;
    for (int i = 0; i < 16; i++) begin
      v = {i[2:0], i[3:0], 1'b0};
      wr_reg(LIC_OFS_CTRL_TWO, {i[0], 7'h00});
      wr_reg(LIC_OFS_CTRL_ONE, v);
      rd_chk("ctrl one", LIC_OFS_CTRL_ONE, v);
      chk("ja on", !v[1], ja_enable);
      chk("depth", v[2] ? LIC_JA_SHALLOW : LIC_JA_DEEP, ja_depth);
      chk("side", v[3], ja_tx);
      chk("eq", i[0] ? (v[4] ? LIC_EGL_E1_LONG : LIC_EGL_E1_SHORT)
        : (v[4] ? LIC_EGL_T1_LIM : LIC_EGL_T1_FULL), eq_limit_db);
      chk("bo", v[7:5], buildout_sel);
    end
    wr_reg(LIC_OFS_GAIN, 8'hff);
    rd_chk("gain", LIC_OFS_GAIN, 8'h7f);
    chk("manual gain", 8'h3f, tx_gain);
    wr_reg(LIC_OFS_GAIN, 8'h3f);
    rd_chk("gain", LIC_OFS_GAIN, 8'h3f);
    chk("auto gain", 8'h00, tx_gain);
    $display("test fields done");
  endtask : t_fields

  task automatic t_power();
    logic e;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      pcs <= i[2];
      pin <= i[1];
      wr_reg(LIC_OFS_CTRL_ONE, {7'h00, i[0]});
      repeat (3) @(posedge clk);
      #1 e = i[0] && !(i[2] && i[1]);
      chk("tx on", e, tx_enable);
      chk("float", !e, pos_oe_n);
      chk("float neg", !e, neg_oe_n);
    end
    $display("test power done");
  endtask : t_power

  // feeder outpaces the coder, so the buffer fills and refuses
  task automatic t_tx();
    logic [5:0] bits;
    logic r, lvl, e;
    int k;
    bits = 6'b001101;
    @(posedge clk);
    pcs <= 1'b0;
    pin <= 1'b0;
    wr_reg(LIC_OFS_CTRL_FOUR, 8'h80);
    wr_reg(LIC_OFS_CTRL_ONE, 8'h01);
    rd_chk("status", LIC_OFS_STATUS, 8'h03);
    @(posedge clk);
    fork
      begin
        for (int b = 0; b < 6; b++) begin
          tx_data <= bits[b];
          tx_valid <= 1'b1;
          do begin
            #1 r = tx_ready;
            @(posedge clk);
          end while (!r);
        end
        // drop valid at the edge that took the last bit
        tx_valid <= 1'b0;
      end
      begin
        k = 0;
        do begin
          @(posedge clk);
          #1 k++;
        end while (tx_line_pos !== 1'b1 && k < 40);
        lvl = 1'b0;
        for (int j = 0; j < 24; j++) begin
          if (bits[j / 4] && j % 4 == 0)
            lvl = ~lvl;
          e = bits[j / 4] ? lvl : (j % 4 >= 2);
          chk("line", e, tx_line_pos);
          @(posedge clk);
          #1;
        end
      end
    join
    chk("drive", 8'h00, pos_oe_n);
    chk("neg low", 8'h00, tx_line_neg);
    repeat (8) @(posedge clk);
    #1 chk("drained", 8'h01, tx_ready);
    $display("test tx done");
  endtask : t_tx

  // zeros decode to zero whatever the pair alignment; a mixed pattern
  // then starts one edge after cmi comes on, so the pairs line up
  task automatic t_rx();
    int k;
    k = 0;
    @(posedge clk);
    send <= 1'b1;
    repeat (40) begin
      @(posedge clk);
      #1;
      if (rx_clk_en === 1'b1) begin
        k++;
        if (k > 2)
          chk("rx bit", 8'h00, rx_data);
      end
    end
    chk("rx pulses", 8'h01, k >= 9);
    @(posedge clk);
    send <= 1'b0;
    pattern <= 8'hb2;
    wr_reg(LIC_OFS_CTRL_FOUR, 8'h00);
    wr_reg(LIC_OFS_CTRL_FOUR, 8'h80);
    send <= 1'b1;
    k = 0;
    repeat (40) begin
      @(posedge clk);
      #1;
      if (rx_clk_en === 1'b1) begin
        chk("rx mixed", pattern[k % 8], rx_data);
        k++;
      end
    end
    chk("rx mixed pulses", 8'h01, k == 10);
    @(posedge clk);
    send <= 1'b0;
    $display("test rx done");
  endtask : t_rx

  // ----------------------------------------
  // run control
  // ----------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_fields();
    t_power();
    t_tx();
    t_rx();
    close_out();
  end
endmodule : test_line_interface_control_cmi
